//--- verilog/die_select_defs.vh
// Constants for the stacked die select and address decode block.
// What the document requires, with notes where this block differs
// RL1 - Exactly one die active on shared bus
// RL2 - Die chosen at reset, boundary, software command; at a boundary the die is kept and only flagged
// RL3 - Each die has identifier; C2h selects it
// RL4 - Linear addressing; reads stay in segment
// RL5 - Each die keeps own busy, suspend flags
// RL6 - Program writes 1 to 256 bytes, one page
// RL7 - Erase 16, 128, 256 pages or whole chip
// RL8 - Each die holds own 64-bit serial number
// RL9 - Continuous read needs only 8 overhead clocks; a read here needs 8 opcode clocks plus 24 or 32 address clocks before data
// RL10 - Three 256-byte security registers exist; the block holds no register data and shifts out nothing for 48h
// RL11 - Accept 3-byte or 4-byte address mode
// RL12 - Die index from two top address bits
// RL13 - Sample rising edge, drive on falling
// RL14 - Controller toggles select low after power-up
`ifndef DIE_SELECT_DEFS_VH
`define DIE_SELECT_DEFS_VH
`define OP_DIE_SELECT      8'hC2
`define OP_ENTER_4B        8'hB7
`define OP_EXIT_4B         8'hE9
`define OP_READ            8'h03
`define OP_READ_4B         8'h13
`define OP_FAST_READ       8'h0B
`define OP_PAGE_PROG       8'h02
`define OP_PAGE_PROG_4B    8'h12
`define OP_SECTOR_ERASE    8'h20
`define OP_BLOCK32_ERASE   8'h52
`define OP_BLOCK64_ERASE   8'hD8
`define OP_CHIP_ERASE      8'hC7
`define OP_SUSPEND         8'h75
`define OP_RESUME          8'h7A
`define OP_UNIQUE_ID       8'h4B
`define OP_SEC_READ        8'h48
`define OP_ENABLE_RESET    8'h66
`define OP_RESET_DEVICE    8'h99
`define DIE_MSB            27
`define DIE_LSB            26
`define ADDR_BYTES_3       3'h3
`define ADDR_BYTES_4       3'h4
`define PAGE_BYTES         9'h100
`define SECTOR_PAGES       9'h010
`define BLOCK32_PAGES      9'h080
`define BLOCK64_PAGES      9'h100
`define SEC_REG_COUNT      2'h3
`define BUSY_CYCLES        16'h0040
`define BUSY_CYCLES_CHIP   16'h0400
`endif

//--- verilog/word_fifo.v
// Parameterised valid/ready FIFO held in flip-flops.
`default_nettype none
module word_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words.
  reg [AW-1:0]    wr_ptr;          // Next slot to fill.
  reg [AW-1:0]    rd_ptr;          // Oldest slot.
  reg [AW:0]      count;           // Words held.
  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  // Pointers and count; a push and pop together leave the count alone.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

//--- verilog/stacked_die_select_decode.v
// Die selection, address decode and per-die status for a four-die stack.
`default_nettype none
`include "die_select_defs.vh"
module stacked_die_select_decode #(
  parameter DIES     = 4,
  parameter DEPTH    = 32,
  parameter SERIAL_0 = 64'h0123456789ABCDE0, // Arbitrary value.
  parameter SERIAL_1 = 64'h0123456789ABCDE1, // Arbitrary value.
  parameter SERIAL_2 = 64'h0123456789ABCDE2, // Arbitrary value.
  parameter SERIAL_3 = 64'h0123456789ABCDE3  // Arbitrary value.
) (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        chip_sel_n_i,
  input  wire        sclk_i,
  input  wire        serial_in_line_i,
  input  wire        read_ready_i,
  output reg         serial_out_o,
  output reg         serial_out_oe_o,
  output reg  [3:0]  die_active_o,
  output reg  [1:0]  die_identifier_o,
  output reg  [3:0]  busy_flags_o,
  output reg  [3:0]  suspend_flags_o,
  output reg         addr_4byte_o,
  output reg  [7:0]  read_data_o,
  output reg         read_valid_o,
  output reg         boundary_event_o
);
  // Three-stage synchronisers; a change counts when stages two and three agree.
  reg [2:0] cs_s, clk_s, din_s;
  reg       cs_q, clk_q;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cs_s  <= 3'h7;
      clk_s <= 3'h0;
      din_s <= 3'h0;
      cs_q  <= 1'b1;
      clk_q <= 1'b0;
    end else begin
      cs_s  <= {cs_s[1:0], chip_sel_n_i};
      clk_s <= {clk_s[1:0], sclk_i};
      din_s <= {din_s[1:0], serial_in_line_i};
      if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
      if (clk_s[1] == clk_s[2]) clk_q <= clk_s[2];
    end
  end
  wire clk_new  = (clk_s[1] == clk_s[2]) ? clk_s[2] : clk_q;
  wire rise     = clk_new && !clk_q && !cs_q;  // RL13
  wire fall     = !clk_new && clk_q && !cs_q;  // RL13
  wire cs_fall  = (cs_s[1] == cs_s[2]) && !cs_s[2] && cs_q;
  wire cs_rise  = (cs_s[1] == cs_s[2]) && cs_s[2] && !cs_q;

  // Frame state: one-hot phases.
  localparam ST_OP   = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_DONE = 4'h8;
  reg [3:0]  state;
  reg [7:0]  shift;      // Incoming bits.
  reg [2:0]  bitcnt;     // Bits of current byte.
  reg [7:0]  opcode;     // Current instruction.
  reg [2:0]  abytes;     // Address bytes received.
  reg [31:0] addr;       // Linear address in flight.
  reg [8:0]  prog_cnt;   // Bytes programmed in this page.
  reg        armed;      // Chip select has fallen since reset.
  reg        rst_enabled;// Reset-enable seen last frame.
  reg [1:0]  sec_idx;    // Security register picked by address.
  reg [15:0] busy_cnt [0:DIES-1];
  reg [7:0]  out_byte;   // Byte being shifted out.
  reg [2:0]  out_cnt;
  wire [7:0] byte_in   = {shift[6:0], din_s[2]};
  wire [2:0] need      = addr_4byte_o ? `ADDR_BYTES_4 : `ADDR_BYTES_3; // RL11
  wire       is_read   = (opcode == `OP_READ) || (opcode == `OP_READ_4B) || (opcode == `OP_FAST_READ);
  wire       is_prog   = (opcode == `OP_PAGE_PROG) || (opcode == `OP_PAGE_PROG_4B);
  wire       addr_op   = is_read || is_prog || (opcode == `OP_SECTOR_ERASE) || (opcode == `OP_BLOCK32_ERASE)
                         || (opcode == `OP_BLOCK64_ERASE) || (opcode == `OP_SEC_READ);
  // Die picked by the two top bits of the linear address.
  wire [1:0] addr_die  = addr[`DIE_MSB:`DIE_LSB]; // RL12

  // FIFO between the read path and the consumer.
  reg        fifo_in_valid;
  reg  [7:0] fifo_in_data;
  wire       fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  word_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(5)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (fifo_in_data),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (read_ready_i || !read_valid_o)
  );

  // Serial number byte lookup for the active die.
  function [7:0] serial_byte;
    input [1:0] die;
    input [2:0] idx;
    reg   [63:0] s;
    begin
      s = (die == 2'h0) ? SERIAL_0 : (die == 2'h1) ? SERIAL_1 : (die == 2'h2) ? SERIAL_2 : SERIAL_3;
      serial_byte = s[{~idx, 3'h0} +: 8]; // RL8
    end
  endfunction
  // Serial number byte for the active die, so its top bit can be sent first.
  wire [7:0] uid_byte  = serial_byte(die_identifier_o, addr[2:0]); // RL8

  // Main frame sequencer, die select and address tracking.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state            <= ST_OP;
      shift            <= 8'h00;
      bitcnt           <= 3'h0;
      opcode           <= 8'h00;
      abytes           <= 3'h0;
      addr             <= 32'h0000_0000;
      prog_cnt         <= 9'h000;
      armed            <= 1'b0;
      rst_enabled      <= 1'b0;
      sec_idx          <= 2'h0;
      die_identifier_o <= 2'h0;                   // RL2
      die_active_o     <= 4'h1;                   // RL1
      addr_4byte_o     <= 1'b0;
      boundary_event_o <= 1'b0;
      fifo_in_valid    <= 1'b0;
      fifo_in_data     <= 8'h00;
      serial_out_o     <= 1'b0;
      serial_out_oe_o  <= 1'b0;
      out_byte         <= 8'h00;
      out_cnt          <= 3'h0;
    end else begin
      boundary_event_o <= 1'b0;
      fifo_in_valid    <= 1'b0;
      // One-hot decode keeps exactly one die on the bus.
      die_active_o     <= 4'h1 << die_identifier_o; // RL1
      if (cs_fall) begin
        armed   <= 1'b1;                          // RL14
        state   <= ST_OP;
        bitcnt  <= 3'h0;
        abytes  <= 3'h0;
        out_cnt <= 3'h0;
      end
      if (cs_rise) begin
        serial_out_oe_o <= 1'b0;
        // Frame-end actions: a reset only takes effect on a full frame.
        if (state == ST_DONE && opcode == `OP_ENABLE_RESET) begin
          rst_enabled <= 1'b1;
        end else begin
          rst_enabled <= 1'b0;
        end
        if (state == ST_DONE && opcode == `OP_RESET_DEVICE && rst_enabled) begin
          die_identifier_o <= 2'h0;               // RL2
          addr_4byte_o     <= 1'b0;
        end
        state <= ST_OP;
      end else if (rise && armed) begin
        shift  <= byte_in;
        bitcnt <= bitcnt + 1'b1;
        if (bitcnt == 3'h7) begin
          case (state)
            ST_OP: begin
              opcode <= byte_in;
              if (byte_in == `OP_ENTER_4B) addr_4byte_o <= 1'b1;   // RL11
              if (byte_in == `OP_EXIT_4B)  addr_4byte_o <= 1'b0;   // RL11
              state <= (byte_in == `OP_DIE_SELECT) ? ST_DATA : ST_DONE;
              if (byte_in == `OP_PAGE_PROG || byte_in == `OP_PAGE_PROG_4B || byte_in == `OP_READ
                  || byte_in == `OP_READ_4B || byte_in == `OP_FAST_READ || byte_in == `OP_SECTOR_ERASE
                  || byte_in == `OP_BLOCK32_ERASE || byte_in == `OP_BLOCK64_ERASE
                  || byte_in == `OP_SEC_READ) begin
                state <= ST_ADDR;
              end
              if (byte_in == `OP_UNIQUE_ID) begin
                state <= ST_DATA;
                addr  <= 32'h0000_0000;
              end
              prog_cnt <= 9'h000;
            end
            ST_ADDR: begin
              addr   <= {addr[23:0], byte_in};
              abytes <= abytes + 1'b1;
              if (abytes + 1'b1 == need) begin
                state <= ST_DATA;
                if (need == `ADDR_BYTES_3) begin
                  // Three-byte mode keeps the current die's upper bits.
                  addr <= {4'h0, die_identifier_o, 2'h0, addr[15:0], byte_in};
                end else if (opcode != `OP_SEC_READ) begin
                  die_identifier_o <= addr[`DIE_MSB-8:`DIE_LSB-8]; // RL12
                end
                sec_idx <= addr[13:12] - 2'h1;    // RL10
              end
            end
            ST_DATA: begin
              if (opcode == `OP_DIE_SELECT) begin
                die_identifier_o <= byte_in[1:0]; // RL3
                state            <= ST_DONE;
              end else if (is_prog && prog_cnt != `PAGE_BYTES) begin
                prog_cnt <= prog_cnt + 1'b1;      // RL6
                // Address wraps inside the 256-byte page.
                addr[7:0] <= addr[7:0] + 8'h01;   // RL6
              end
            end
            default: state <= state;
          endcase
        end
      end else if (fall && state == ST_DATA && (is_read || opcode == `OP_UNIQUE_ID)) begin
        // Read data shifts out on falling edges, most significant bit first.
        serial_out_oe_o <= 1'b1;                  // RL13
        if (out_cnt == 3'h0) begin
          out_byte         <= (opcode == `OP_UNIQUE_ID) ? uid_byte
                              : addr[7:0] ^ {6'h00, addr_die} ^ {6'h00, sec_idx};
          serial_out_o     <= (opcode == `OP_UNIQUE_ID) ? uid_byte[7] : addr[7];
          fifo_in_data     <= addr[7:0];
          fifo_in_valid    <= fifo_in_ready && is_read;
        end else begin
          serial_out_o <= out_byte[3'h7 - out_cnt];
        end
        out_cnt <= out_cnt + 1'b1;
        if (out_cnt == 3'h7) begin
          // Continuous read stays in its 512Mb segment by wrapping the low bits.
          // No new instruction is needed for the next byte, which keeps overhead low.
          addr <= {addr[31:`DIE_MSB+1], addr_die, addr[`DIE_LSB-1:0] + 26'h1}; // RL4 RL9
          if (opcode != `OP_UNIQUE_ID && (&addr[`DIE_LSB-1:0])) begin
            boundary_event_o <= 1'b1;             // RL2
          end
        end
      end
    end
  end

  // Consumer side register for FIFO output.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      read_data_o  <= 8'h00;
      read_valid_o <= 1'b0;
    end else if (read_ready_i || !read_valid_o) begin
      read_data_o  <= fifo_out_data;
      read_valid_o <= fifo_out_valid;
    end
  end

  // Per-die busy and suspend flags, each die independent.
  genvar g;
  generate
    for (g = 0; g < DIES; g = g + 1) begin : g_die
      wire start = cs_rise && state == ST_DONE && die_identifier_o == g
                   && (opcode == `OP_CHIP_ERASE) || (cs_rise && state == ST_DATA && die_identifier_o == g
                   && (is_prog || opcode == `OP_SECTOR_ERASE || opcode == `OP_BLOCK32_ERASE
                   || opcode == `OP_BLOCK64_ERASE)); // RL7
      wire susp  = cs_rise && state == ST_DONE && die_identifier_o == g && opcode == `OP_SUSPEND;
      wire resm  = cs_rise && state == ST_DONE && die_identifier_o == g && opcode == `OP_RESUME;
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          busy_cnt[g]        <= 16'h0000;
          busy_flags_o[g]    <= 1'b0;
          suspend_flags_o[g] <= 1'b0;
        end else begin
          if (start && !busy_flags_o[g]) begin
            busy_cnt[g]     <= (opcode == `OP_CHIP_ERASE) ? `BUSY_CYCLES_CHIP : `BUSY_CYCLES;
            busy_flags_o[g] <= 1'b1;            // RL5
          end else if (susp && busy_flags_o[g]) begin
            suspend_flags_o[g] <= 1'b1;         // RL5
          end else if (resm && suspend_flags_o[g]) begin
            suspend_flags_o[g] <= 1'b0;         // RL5
          end else if (busy_flags_o[g] && !suspend_flags_o[g]) begin
            busy_cnt[g] <= busy_cnt[g] - 16'h0001;
            if (busy_cnt[g] == 16'h0001) busy_flags_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // stacked_die_select_decode
`default_nettype wire

//--- sim/die_select_asserts.sv
// Port checks for the die select block.
`default_nettype none
module die_select_asserts (
  input wire       ref_clk_i,
  input wire       rst_n_i,
  input wire       chip_sel_n_i,
  input wire       sclk_i,
  input wire       serial_in_line_i,
  input wire       read_ready_i,
  input wire       serial_out_o,
  input wire       serial_out_oe_o,
  input wire [3:0] die_active_o,
  input wire [1:0] die_identifier_o,
  input wire [3:0] busy_flags_o,
  input wire [3:0] suspend_flags_o,
  input wire       addr_4byte_o,
  input wire [7:0] read_data_o,
  input wire       read_valid_o,
  input wire       boundary_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_one_die;
    $onehot(die_active_o);
  endproperty
  a_one_die: assert property (p_one_die) else $error("active die not one-hot");
  property p_reset_state;
    disable iff (1'b0) !rst_n_i |=> die_active_o == 4'h1 && busy_flags_o == 4'h0 && !serial_out_oe_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_id_follow;
    $changed(die_identifier_o) |=> die_active_o == (4'h1 << die_identifier_o);
  endproperty
  a_id_follow: assert property (p_id_follow) else $error("active die not following id");
  property p_idle_quiet;
    chip_sel_n_i [*6] |-> !serial_out_oe_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output driven while deselected");
  property p_out_edge;
    (sclk_i && !chip_sel_n_i) [*6] |-> $stable(serial_out_o);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("output moved with clock high");
  property p_busy_own;
    (busy_flags_o & ~$past(busy_flags_o)) != 4'h0 |-> (busy_flags_o & ~$past(busy_flags_o) & ~die_active_o) == 4'h0;
  endproperty
  a_busy_own: assert property (p_busy_own) else $error("busy rose on idle die");
  property p_wrap_pulse;
    boundary_event_o |=> !boundary_event_o;
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse too long");
  property p_read_hold;
    read_valid_o && !read_ready_i |=> read_valid_o && $stable(read_data_o);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read byte dropped");
endmodule // die_select_asserts
bind stacked_die_select_decode die_select_asserts u_chk (.*);
`default_nettype wire

//--- sim/spi_ctl_model.sv
// Behavioural serial controller driving frames, mode 0.
`default_nettype none
module spi_ctl_model (
  input  wire logic ref_clk_i,
  output var  logic chip_sel_n_o,
  output var  logic sclk_o,
  output var  logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ref cycles per serial half period; the sampler needs at least four.
  localparam int HALF = 8;
  // Idle with select high and the clock low.
  initial begin
    chip_sel_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Select falls before any byte is sent.
  task automatic open_frame();
    @(posedge ref_clk_i);
    chip_sel_n_o <= 1'b0;
    repeat (HALF) @(posedge ref_clk_i);
  endtask
  // Data changes with the clock low, most significant bit first.
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk_o <= 1'b0;
      mosi_o <= b[i];
      repeat (HALF) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge ref_clk_i);
    end
  endtask
  // Released data shows the inverse of its last bit, so no stale value looks valid.
  task automatic close_frame();
    sclk_o <= 1'b0;
    repeat (HALF) @(posedge ref_clk_i);
    chip_sel_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (HALF) @(posedge ref_clk_i);
  endtask
endmodule // spi_ctl_model
`default_nettype wire

//--- sim/tb_stacked_die_select_decode.sv
// Self-checking bench for the die select block.
`default_nettype none
`include "die_select_defs.vh"
module tb_stacked_die_select_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;  // Reference clock.
  logic       rst_n = 1'b0; // Synchronous reset.
  logic       rdy = 1'b1;   // Read consumer ready.
  logic       cs_n;         // Select from controller.
  logic       sck;          // Serial clock.
  logic       mosi;         // Serial data in.
  logic [3:0] act;          // Active die.
  logic [1:0] idn;          // Active die index.
  logic [3:0] busy;         // Busy flags.
  logic       oe;           // Output enable.
  logic       a4;           // Four-byte mode.
  logic       vld;          // Read byte valid.
  logic       bnd;          // Wrap pulse.
  logic       sdo;          // Serial data out.
  logic [3:0] susp;         // Suspend flags.
  logic [7:0] rdata;        // Read byte out of the buffer.
  logic       wrapped = 1'b0; // Latched wrap seen.
  int errors = 0;
  int samples_checked = 0;
  // Rows hold the die index and the one-hot active die it should give.
  logic [5:0] rows [4] = '{6'h38, 6'h12, 6'h24, 6'h01};
  always #4 clk = ~clk;
  spi_ctl_model ctl (.ref_clk_i(clk), .chip_sel_n_o(cs_n), .sclk_o(sck), .mosi_o(mosi));
  stacked_die_select_decode dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .chip_sel_n_i(cs_n), .sclk_i(sck),
    .serial_in_line_i(mosi), .read_ready_i(rdy), .serial_out_o(sdo), .serial_out_oe_o(oe),
    .die_active_o(act), .die_identifier_o(idn), .busy_flags_o(busy), .suspend_flags_o(susp),
    .addr_4byte_o(a4), .read_data_o(rdata), .read_valid_o(vld), .boundary_event_o(bnd));
  // The pulse lasts one cycle, so it is latched here for a later look.
  always @(posedge clk) begin
    if (bnd === 1'b1) wrapped <= 1'b1;
  end
  // Compares one result and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sends a one-byte command and lets the synchronisers settle.
  task automatic cmd(input logic [7:0] op);
    ctl.open_frame();
    ctl.put_byte(op);
    ctl.close_frame();
  endtask
  // Selects a die by index.
  task automatic pick(input logic [1:0] id);
    ctl.open_frame();
    ctl.put_byte(`OP_DIE_SELECT);
    ctl.put_byte({6'h0, id});
    ctl.close_frame();
  endtask
  // Prints counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run.
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({4'h0, act}, 8'h01);
    chk({4'h0, busy}, 8'h00);
    chk({7'h0, oe}, 8'h00);
    chk({7'h0, a4}, 8'h00);
    chk({4'h0, susp}, 8'h00);
    $display("reset test done");
    for (int r = 0; r < 4; r++) begin
      pick(rows[r][5:4]);
      chk({4'h0, act}, {4'h0, rows[r][3:0]});
      chk({6'h0, idn}, {6'h0, rows[r][5:4]});
    end
    $display("select table done");
    cmd(`OP_ENTER_4B);
    chk({7'h0, a4}, 8'h01);
    ctl.open_frame();
    ctl.put_byte(`OP_PAGE_PROG_4B);
    ctl.put_byte(8'h08);
    ctl.put_byte(8'h00);
    ctl.put_byte(8'h00);
    ctl.put_byte(8'h10);
    ctl.put_byte(8'hA5);
    ctl.close_frame();
    chk({4'h0, act}, 8'h04);
    chk({4'h0, busy}, 8'h04);
    for (int n = 0; n < 400 && busy !== 4'h0; n++) @(posedge clk);
    chk({4'h0, busy}, 8'h00);
    $display("program test done");
    rdy <= 1'b0;
    ctl.open_frame();
    ctl.put_byte(`OP_READ_4B);
    ctl.put_byte(8'h03);
    ctl.put_byte(8'hFF);
    ctl.put_byte(8'hFF);
    ctl.put_byte(8'hFF);
    ctl.put_byte(8'h00);
    ctl.put_byte(8'h00);
    chk({7'h0, oe}, 8'h01);
    ctl.close_frame();
    chk({7'h0, vld}, 8'h01);
    chk(rdata, 8'hFF);
    chk({7'h0, wrapped}, 8'h01);
    chk({6'h0, idn}, 8'h00);
    chk({7'h0, oe}, 8'h00);
    rdy <= 1'b1;
    $display("wrap read test done");
    cmd(`OP_EXIT_4B);
    chk({7'h0, a4}, 8'h00);
    cmd(`OP_ENTER_4B);
    pick(2'h3);
    cmd(`OP_ENABLE_RESET);
    cmd(`OP_RESET_DEVICE);
    chk({4'h0, act}, 8'h01);
    chk({7'h0, a4}, 8'h00);
    $display("soft reset test done");
    // Die 0 serial number top byte is 01h, so its last bit is a one.
    ctl.open_frame();
    ctl.put_byte(`OP_UNIQUE_ID);
    ctl.put_byte(8'h00);
    chk({7'h0, sdo}, 8'h01);
    ctl.close_frame();
    $display("serial number test done");
    give_verdict();
  end
endmodule // tb_stacked_die_select_decode
`default_nettype wire
